// *** common/ept_pkg.sv ***
`default_nettype none
package ept_pkg;
  localparam int SAMPLE_W = 16;
  localparam int POWER_W  = SAMPLE_W + 1 + SAMPLE_W;
  localparam int ACC_W    = 48;
  localparam int IRQ_W    = 3;
  localparam int ADDR_W   = 12;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] REG_MASK   = 12'h008;
  localparam logic [ADDR_W-1:0] REG_POWER  = 12'h00c;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 12'h010;

  localparam int           CTRL_RUN_BIT = 0;
  localparam logic         CTRL_RUN_RST = 1'b1;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

  // status and mask bit positions
  localparam int IRQ_CAL    = 0;
  localparam int IRQ_ENERGY = 1;
  localparam int IRQ_REV    = 2;

  // filter corner shifts
  localparam int HPF_SHIFT = 10;
  localparam int LPF_SHIFT = 14;

  // energy thresholds per rate select, calibration divides them down
  typedef logic [ACC_W-1:0] ept_acc_t;
  localparam ept_acc_t ENERGY_THR [4] = '{
    48'h0000_4000_0000_0000 >> 8,
    48'h0000_2000_0000_0000 >> 8,
    48'h0000_1000_0000_0000 >> 8,
    48'h0000_0800_0000_0000 >> 8
  };
  localparam int CAL_SHIFT_LO = 6;
  localparam int CAL_SHIFT_HI = 4;

  // pulse widths
  localparam int CLK_MHZ        = 100;
  localparam int CAL_PULSE_NS   = 1000;
  localparam int CAL_PULSE_CYC  = (CAL_PULSE_NS * CLK_MHZ) / 1000;
  localparam int ENERGY_PULSE_MS = 100;
  localparam int ENERGY_PULSE_CYC_DFLT = ENERGY_PULSE_MS * CLK_MHZ * 1000;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_A    = 2'b01,
    SEQ_GAP  = 2'b11,
    SEQ_B    = 2'b10
  } ept_seq_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } ept_apb_req_t;
endpackage
`default_nettype wire

// *** hw/ept_core.sv ***
// The register offsets and the APB interface to the registers are this design's own decisions.
`default_nettype none
// Functional notes
// [RQ1] cal select level picks calibration pulse rate
// [RQ2] two rate selects pick one of four rates
// [RQ3] reverse flag high when real power negative
// [RQ4] reverse flag falls again on positive power
// [RQ5] reverse flag changes only with a calibration pulse
// [RQ6] calibration pulse uses short integration time
// [RQ7] energy pulses accumulate power over long interval
// [RQ8] energy pulses alternate for counter or stepper
// [RQ9] take 16-bit current and voltage samples
// [RQ10] current channel always high-pass filtered
// [RQ11] power is filtered current times voltage
// [RQ12] low-pass the product to get real power
// [RQ13] integrate real power into pulse frequency
// [RQ14] supply low keeps all pulse outputs inactive
// [RQ15] one clock; reset clears accumulators, outputs low
module ept_core #(
  parameter int unsigned ENERGY_PULSE_CYC = ept_pkg::ENERGY_PULSE_CYC_DFLT
) (
  input  wire logic                          clock_i,       // 100 MHz
  input  wire logic                          rst_b_i,       // async, low
  input  wire logic                          ce_i,          // clock enable
  input  wire logic                          supply_ok_i,   // supply >= 4 V
  input  wire logic signed [ept_pkg::SAMPLE_W-1:0] cur_sample_i, // current
  input  wire logic signed [ept_pkg::SAMPLE_W-1:0] volt_sample_i, // voltage
  input  wire logic                          sample_vld_i,  // sample strobe
  input  wire logic                          cal_rate_select_i,  // cal rate
  input  wire logic                          conv_rate_sel_hi_i, // rate msb
  input  wire logic                          conv_rate_sel_lo_i, // rate lsb
  input  wire ept_pkg::ept_apb_req_t         apb_i,         // apb request
  output logic [31:0]                        prdata_o,      // apb read data
  output logic                               pready_o,      // apb ready
  output logic                               pslverr_o,     // apb error
  output logic                               irq_o,         // interrupt
  output logic                               calibration_pulse_out_o, // cal
  output logic                               energy_pulse_a_o, // phase a
  output logic                               energy_pulse_b_o, // phase b
  output logic                               reverse_power_flag_o // rev
);
  import ept_pkg::*;

  localparam int ECW = $clog2(ENERGY_PULSE_CYC + 1);
  localparam int CCW = $clog2(CAL_PULSE_CYC + 1);
  localparam logic [ECW-1:0] E_LAST = ECW'(ENERGY_PULSE_CYC - 1);
  localparam logic [CCW-1:0] C_LAST = CCW'(CAL_PULSE_CYC - 1);

  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  logic                       run_q;
  logic [IRQ_W-1:0]           sts_q;
  logic [IRQ_W-1:0]           mask_q;
  logic [31:0]                count_q;
  logic signed [POWER_W-1:0]  prod_q;
  logic                       prod_vld_q;
  logic                       lpf_vld_q;
  logic [CCW-1:0]             cal_cnt_q;
  logic [ECW-1:0]             e_cnt_q;
  logic                       pend_q;
  ept_seq_t                   seq_q;
  logic signed [SAMPLE_W-1:0] cur_lp;
  logic signed [POWER_W-1:0]  lpf_y;
  logic                       cal_fire;
  logic                       energy_fire;

  wire logic clr_w = !supply_ok_i || !run_q; // [RQ14]

  // dc estimate of the current channel, subtracted below
  ept_ema_filter #(.W(SAMPLE_W), .SHIFT(HPF_SHIFT)) u_hpf_dc (
    .clock_i (clock_i),
    .rst_n_i (rst_n_q),
    .ce_i    (ce_i),
    .clr_i   (clr_w),
    .en_i    (sample_vld_i), // [RQ9]
    .x_i     (cur_sample_i),
    .y_o     (cur_lp)
  );

  wire logic signed [SAMPLE_W:0] cur_hp_w =
    (SAMPLE_W+1)'(cur_sample_i) - (SAMPLE_W+1)'(cur_lp); // [RQ10]
  wire logic signed [POWER_W-1:0] prod_w =
    POWER_W'(cur_hp_w * volt_sample_i); // [RQ11]

  ept_ema_filter #(.W(POWER_W), .SHIFT(LPF_SHIFT)) u_lpf (
    .clock_i (clock_i),
    .rst_n_i (rst_n_q),
    .ce_i    (ce_i),
    .clr_i   (clr_w),
    .en_i    (prod_vld_q), // [RQ12]
    .x_i     (prod_q),
    .y_o     (lpf_y)
  );

  wire logic [1:0]  conv_sel_w   = {conv_rate_sel_hi_i, conv_rate_sel_lo_i};
  wire ept_acc_t    energy_thr_w = ENERGY_THR[conv_sel_w]; // [RQ2]
  // fewer energy units per pulse gives the faster calibration rate
  wire ept_acc_t    cal_thr_w    = cal_rate_select_i ?
    (energy_thr_w >> CAL_SHIFT_HI) : (energy_thr_w >> CAL_SHIFT_LO); // [RQ1]

  ept_dfc #(.PW(POWER_W), .AW(ACC_W)) u_cal_dfc (
    .clock_i (clock_i),
    .rst_n_i (rst_n_q),
    .ce_i    (ce_i),
    .clr_i   (clr_w),
    .step_i  (lpf_vld_q), // [RQ13]
    .power_i (lpf_y),
    .thr_i   (cal_thr_w), // [RQ6]
    .fire_o  (cal_fire)
  );

  ept_dfc #(.PW(POWER_W), .AW(ACC_W)) u_energy_dfc (
    .clock_i (clock_i),
    .rst_n_i (rst_n_q),
    .ce_i    (ce_i),
    .clr_i   (clr_w),
    .step_i  (lpf_vld_q), // [RQ13]
    .power_i (lpf_y),
    .thr_i   (energy_thr_w), // [RQ7]
    .fire_o  (energy_fire)
  );

  always_ff @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      prod_q     <= '0;
      prod_vld_q <= 1'b0;
      lpf_vld_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      prod_vld_q <= sample_vld_i && !clr_w;
      lpf_vld_q  <= prod_vld_q && !clr_w;
      if (sample_vld_i)
        prod_q <= prod_w;
    end
  end

  // calibration pulse and reverse flag share one update edge
  wire logic neg_w     = lpf_y[POWER_W-1];
  wire logic rev_chg_w = cal_fire && !clr_w && (neg_w != reverse_power_flag_o);

  always_ff @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      calibration_pulse_out_o <= 1'b0; // [RQ15]
      cal_cnt_q               <= '0;
      reverse_power_flag_o    <= 1'b0;
    end
    else if (ce_i)
    begin
      if (clr_w)
      begin
        calibration_pulse_out_o <= 1'b0; // [RQ14]
        cal_cnt_q               <= '0;
      end
      else if (cal_fire)
      begin
        calibration_pulse_out_o <= 1'b1; // [RQ6]
        cal_cnt_q               <= C_LAST;
        reverse_power_flag_o    <= neg_w; // [RQ3] [RQ4] [RQ5]
      end
      else if (cal_cnt_q != '0)
        cal_cnt_q <= cal_cnt_q - 1'b1;
      else
        calibration_pulse_out_o <= 1'b0;
    end
  end

  // a and b alternate so a two-phase stepper advances one step per pulse;
  // one pulse that lands during a busy phase is held, not lost
  wire logic e_start_w = energy_fire || pend_q;

  always_ff @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      seq_q            <= SEQ_IDLE;
      e_cnt_q          <= '0;
      pend_q           <= 1'b0;
      energy_pulse_a_o <= 1'b0;
      energy_pulse_b_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (clr_w)
      begin
        seq_q            <= SEQ_IDLE;
        pend_q           <= 1'b0;
        energy_pulse_a_o <= 1'b0; // [RQ14]
        energy_pulse_b_o <= 1'b0;
      end
      else
      begin
        case (seq_q)
          SEQ_IDLE:
            if (e_start_w)
            begin
              energy_pulse_a_o <= 1'b1; // [RQ8]
              e_cnt_q          <= E_LAST;
              pend_q           <= 1'b0;
              seq_q            <= SEQ_A;
            end
          SEQ_A:
          begin
            if (energy_fire)
              pend_q <= 1'b1;
            if (e_cnt_q == '0)
            begin
              energy_pulse_a_o <= 1'b0;
              seq_q            <= SEQ_GAP;
            end
            else
              e_cnt_q <= e_cnt_q - 1'b1;
          end
          SEQ_GAP:
            if (e_start_w)
            begin
              energy_pulse_b_o <= 1'b1; // [RQ8]
              e_cnt_q          <= E_LAST;
              pend_q           <= 1'b0;
              seq_q            <= SEQ_B;
            end
          SEQ_B:
          begin
            if (energy_fire)
              pend_q <= 1'b1;
            if (e_cnt_q == '0)
            begin
              energy_pulse_b_o <= 1'b0;
              seq_q            <= SEQ_IDLE;
            end
            else
              e_cnt_q <= e_cnt_q - 1'b1;
          end
          default:
            seq_q <= SEQ_IDLE;
        endcase
      end
    end
  end

  // apb slave: one wait state so read data leaves a flip-flop
  wire logic acc_w  = apb_i.psel && apb_i.penable;
  wire logic done_w = acc_w && pready_o;
  wire logic wr_w   = done_w && apb_i.pwrite;
  logic [31:0] rd_w;
  logic        hit_w;

  always_comb
  begin
    rd_w  = 32'h0000_0000;
    hit_w = 1'b1;
    if (apb_i.paddr == REG_CTRL)
      rd_w = {31'h0000_0000, run_q};
    else if (apb_i.paddr == REG_STATUS)
      rd_w = {29'h0000_0000, sts_q};
    else if (apb_i.paddr == REG_MASK)
      rd_w = {29'h0000_0000, mask_q};
    else if (apb_i.paddr == REG_POWER)
      rd_w = lpf_y[POWER_W-1 -: 32];
    else if (apb_i.paddr == REG_COUNT)
      rd_w = count_q;
    else
      hit_w = 1'b0;
  end

  wire logic [IRQ_W-1:0] ev_w = {rev_chg_w, energy_fire, cal_fire};
  wire logic [IRQ_W-1:0] w1c_w = (wr_w && apb_i.paddr == REG_STATUS) ?
    apb_i.pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      run_q     <= CTRL_RUN_RST;
      mask_q    <= MASK_RST;
      sts_q     <= '0;
      irq_o     <= 1'b0;
      count_q   <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      pready_o  <= acc_w && !pready_o;
      pslverr_o <= acc_w && !pready_o && !hit_w;
      if (acc_w && !pready_o && !apb_i.pwrite)
        prdata_o <= rd_w;
      if (wr_w && apb_i.paddr == REG_CTRL)
        run_q <= apb_i.pwdata[CTRL_RUN_BIT];
      if (wr_w && apb_i.paddr == REG_MASK)
        mask_q <= apb_i.pwdata[IRQ_W-1:0];
      // a new event outranks a clear in the same cycle
      sts_q   <= (sts_q & ~w1c_w) | ev_w;
      irq_o   <= |(sts_q & mask_q);
      if (energy_fire)
        count_q <= count_q + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_q);

  property p_rev_at_cal;
    $changed(reverse_power_flag_o) |-> $past(cal_fire) && $past(ce_i);
  endproperty
  a_rev_at_cal: assert property (p_rev_at_cal) // [RQ5]
    else $error("reverse flag moved without a calibration pulse");

  property p_rev_neg;
    ce_i && cal_fire && !clr_w && neg_w |=> reverse_power_flag_o;
  endproperty
  a_rev_neg: assert property (p_rev_neg) // [RQ3]
    else $error("reverse flag not raised on negative power");

  property p_rev_pos;
    ce_i && cal_fire && !clr_w && !neg_w |=> !reverse_power_flag_o;
  endproperty
  a_rev_pos: assert property (p_rev_pos) // [RQ4]
    else $error("reverse flag not released on positive power");

  property p_supply_quiet;
    ce_i && !supply_ok_i |=> !calibration_pulse_out_o && !energy_pulse_a_o
      && !energy_pulse_b_o;
  endproperty
  a_supply_quiet: assert property (p_supply_quiet) // [RQ14]
    else $error("pulse output active while supply is low");

  property p_phase_excl;
    !(energy_pulse_a_o && energy_pulse_b_o) && !(seq_q == SEQ_GAP
      && energy_pulse_a_o);
  endproperty
  a_phase_excl: assert property (p_phase_excl) // [RQ8]
    else $error("energy phases overlap");

  property p_cal_start;
    ce_i && cal_fire && !clr_w |=> calibration_pulse_out_o
      && cal_cnt_q == C_LAST;
  endproperty
  a_cal_start: assert property (p_cal_start) // [RQ6]
    else $error("calibration pulse did not start");

  property p_product;
    ce_i && sample_vld_i |=> prod_q == $past(prod_w);
  endproperty
  a_product: assert property (p_product) // [RQ11]
    else $error("power product not captured");

  property p_energy_start;
    ce_i && energy_fire && !clr_w && seq_q == SEQ_IDLE |=>
      energy_pulse_a_o && seq_q == SEQ_A;
  endproperty
  a_energy_start: assert property (p_energy_start) // [RQ7]
    else $error("energy pulse a did not start");

  property p_irq;
    ce_i && |(sts_q & mask_q) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised for unmasked status");
endmodule
`default_nettype wire

// *** hw/ept_dfc.sv ***
`default_nettype none
// digital-to-frequency converter: integrates |power| and fires per quantum
module ept_dfc #(
  parameter int PW = 33,
  parameter int AW = 48
) (
  input  wire logic                 clock_i, // core clock
  input  wire logic                 rst_n_i, // synchronised reset, low active
  input  wire logic                 ce_i,    // clock enable
  input  wire logic                 clr_i,   // synchronous clear
  input  wire logic                 step_i,  // accumulate this cycle
  input  wire logic signed [PW-1:0] power_i, // filtered real power
  input  wire logic [AW-1:0]        thr_i,   // energy per pulse
  output logic                      fire_o   // one-cycle pulse request
);
  logic [AW-1:0] acc_q;

  // negative power still meters energy; the sign goes to the reverse flag
  wire logic [PW-1:0] mag_w = power_i[PW-1] ? PW'(-power_i) : PW'(power_i);
  wire logic [AW-1:0] sum_w = acc_q + AW'(mag_w);
  wire logic          hit_w = step_i && (sum_w >= thr_i);

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_q  <= '0;
      fire_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (clr_i)
      begin
        acc_q  <= '0;
        fire_o <= 1'b0;
      end
      else
      begin
        fire_o <= hit_w;
        if (hit_w)
          acc_q <= sum_w - thr_i;
        else if (step_i)
          acc_q <= sum_w;
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/ept_ema_filter.sv ***
`default_nettype none
// first-order recursive low pass: y += (x - y) >>> SHIFT per enabled sample
module ept_ema_filter #(
  parameter int W     = 16,
  parameter int SHIFT = 8
) (
  input  wire logic                clock_i, // core clock
  input  wire logic                rst_n_i, // synchronised reset, low active
  input  wire logic                ce_i,    // clock enable
  input  wire logic                clr_i,   // synchronous clear
  input  wire logic                en_i,    // new sample strobe
  input  wire logic signed [W-1:0] x_i,     // sample in
  output logic signed [W-1:0]      y_o      // filtered value
);
  // one guard bit so the difference never wraps
  wire logic signed [W:0] diff_w = (W+1)'(x_i) - (W+1)'(y_o);
  wire logic signed [W:0] step_w = diff_w >>> SHIFT;
  wire logic signed [W:0] sum_w  = (W+1)'(y_o) + step_w;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      y_o <= '0;
    else if (ce_i)
    begin
      if (clr_i)
        y_o <= '0;
      else if (en_i)
        y_o <= sum_w[W-1:0];
    end
  end
endmodule
`default_nettype wire

// *** testbench/ept_core_tb.sv ***
`default_nettype none
module ept_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ept_pkg::*;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } ept_note_t;
  localparam logic signed [SAMPLE_W-1:0] AMP = 16'sh0800;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic supply_ok = 1'b1;
  logic ce = 1'b1;
  logic vld = 1'b0;
  logic cal_sel = 1'b0;
  logic sel_hi = 1'b1;
  logic sel_lo = 1'b1;
  logic neg = 1'b0;
  logic sup_chk = 1'b0;
  logic rev_prev = 1'b0;
  logic cal_prev = 1'b0;
  logic [3:0] ph = 4'h0;
  logic signed [SAMPLE_W-1:0] cur = '0;
  logic signed [SAMPLE_W-1:0] volt = '0;
  ept_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, cal_out, en_a, en_b, rev, seq_err;
  logic [15:0] steps;
  int fails = 0;
  int checks_done = 0;
  int cal_cnt = 0;
  ept_note_t note_q[$];
  ept_note_t nt;

  always #5 clk = ~clk;

  ept_core #(.ENERGY_PULSE_CYC(20)) i_dut (
    .clock_i(clk), .rst_b_i(rst_b), .ce_i(ce), .supply_ok_i(supply_ok),
    .cur_sample_i(cur), .volt_sample_i(volt), .sample_vld_i(vld),
    .cal_rate_select_i(cal_sel), .conv_rate_sel_hi_i(sel_hi),
    .conv_rate_sel_lo_i(sel_lo), .apb_i(req), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
    .calibration_pulse_out_o(cal_out), .energy_pulse_a_o(en_a),
    .energy_pulse_b_o(en_b), .reverse_power_flag_o(rev));

  ept_counter_model i_model (
    .clk_i(clk), .rst_b_i(rst_b), .phase_a_i(en_a), .phase_b_i(en_b),
    .steps_o(steps), .seq_err_o(seq_err));

  // ac square wave so the current high-pass passes it; neg flips voltage
  // seeded in the thread that draws the noise
  initial
  begin
    void'($urandom(32'hbc1d87c6));
    forever
    begin
      @(posedge clk);
      ph   <= ph + 4'h1;
      vld  <= 1'b1;
      cur  <= (ph[3] ? -AMP : AMP) +
        16'($urandom() & 32'h0000_000f);
      volt <= (ph[3] ^ neg) ? -AMP : AMP;
    end
  end

  task automatic print_verdict;
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    // no answer time assumed; the watchdog ends a hang
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic e);
    note_q.push_back('{d: d, m: m, e: e});
    apb(1'b0, a, 32'h0);
  endtask

  always @(posedge clk)
  begin
    if (req.psel && req.penable && !req.pwrite && pready === 1'b1)
    begin
      if (note_q.size() == 0)
        check(32'h0, 32'h1);
      else
      begin
        nt = note_q.pop_front();
        check(prdata & nt.m, nt.d);
        check({31'h0, pslverr}, {31'h0, nt.e});
      end
    end
    if (rst_b)
    begin
      if (rev !== rev_prev)
        check({31'h0, cal_out}, 32'h1);
      if (cal_out && !cal_prev)
        cal_cnt++;
      if (sup_chk)
        check({29'h0, cal_out, en_a, en_b}, 32'h0);
    end
    rev_prev <= rev;
    cal_prev <= cal_out;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial
  begin
    int c0, c1, e0;
    logic [4:0] snap;
    idle(5);
    check({27'h0, irq, cal_out, en_a, en_b, rev}, 32'h0);
    rst_b <= 1'b1;
    idle(4);
    rd(REG_CTRL, 32'h1, 32'hffff_ffff, 1'b0);
    rd(REG_STATUS, 32'h0, 32'hffff_ffff, 1'b0);
    rd(REG_MASK, 32'h0, 32'hffff_ffff, 1'b0);
    apb(1'b1, REG_COUNT, 32'hff);
    rd(REG_COUNT, 32'h0, 32'hffff_ffff, 1'b0);
    rd(12'h020, 32'h0, 32'hffff_ffff, 1'b1);
    idle(16000);
    check({31'h0, rev}, 32'h0);
    rd(REG_POWER, 32'h0, 32'h8000_0000, 1'b0);
    // inputs below only move between windows, static within each
    sel_hi <= 1'b0;
    c0 = cal_cnt;
    idle(8000);
    c0 = cal_cnt - c0;
    cal_sel <= 1'b1;
    c1 = cal_cnt;
    idle(8000);
    c1 = cal_cnt - c1;
    check({31'h0, c0 > 0 && c1 > 0 && ((c0 > 3 * c1 && c0 < 5 * c1) ||
           (c1 > 3 * c0 && c1 < 5 * c0))}, 32'h1);
    cal_sel <= 1'b0;
    sel_lo  <= 1'b0;
    e0 = steps;
    idle(10000);
    check({16'h0, steps}, e0);
    // only a modest step down from the slowest rate: a big one would
    // release a burst of stored quanta and one would be dropped
    sel_hi <= 1'b1;
    e0 = steps;
    idle(10000);
    check({31'h0, steps > e0}, 32'h1);
    sel_lo <= 1'b1;
    neg    <= 1'b1;
    idle(20000);
    check({31'h0, rev}, 32'h1);
    ce <= 1'b0;
    idle(1);
    snap = {irq, cal_out, en_a, en_b, rev};
    // longer than a calibration period, so a running core would move
    idle(300);
    check({27'h0, irq, cal_out, en_a, en_b, rev}, {27'h0, snap});
    ce <= 1'b1;
    rd(REG_POWER, 32'h8000_0000, 32'h8000_0000, 1'b0);
    sel_lo <= 1'b0;
    neg    <= 1'b0;
    idle(20000);
    check({31'h0, rev}, 32'h0);
    supply_ok <= 1'b0;
    idle(2);
    sup_chk <= 1'b1;
    idle(300);
    rd(REG_COUNT, {16'h0, steps}, 32'hffff_ffff, 1'b0);
    check({31'h0, seq_err}, 32'h0);
    check({31'h0, steps > 16'h2}, 32'h1);
    apb(1'b1, REG_MASK, 32'h1);
    idle(2);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, REG_MASK, 32'h0);
    idle(2);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, REG_MASK, 32'h7);
    apb(1'b1, REG_STATUS, 32'h7);
    idle(2);
    check({31'h0, irq}, 32'h0);
    rd(REG_STATUS, 32'h0, 32'h7, 1'b0);
    rd(REG_MASK, 32'h7, 32'hffff_ffff, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0);
    rd(REG_CTRL, 32'h0, 32'hffff_ffff, 1'b0);
    // let the monitor take the last read before the run ends
    idle(2);
    print_verdict;
  end

  initial
  begin
    #990000;
    fails++;
    print_verdict;
  end
endmodule
`default_nettype wire

// *** testbench/ept_counter_model.sv ***
`default_nettype none
// far-side two-phase stepper: one step per energy pulse, phases must alternate
module ept_counter_model (
  input  wire logic   clk_i,     // bench clock
  input  wire logic   rst_b_i,   // reset, low active
  input  wire logic   phase_a_i, // coil a drive
  input  wire logic   phase_b_i, // coil b drive
  output logic [15:0] steps_o,   // pulses seen
  output logic        seq_err_o  // phase order broken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic a_q;
  logic b_q;
  logic last_b_q;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      a_q       <= 1'b0;
      b_q       <= 1'b0;
      last_b_q  <= 1'b1;
      steps_o   <= 16'h0;
      seq_err_o <= 1'b0;
    end
    else
    begin
      a_q <= phase_a_i;
      b_q <= phase_b_i;
      // both coils on at once would stall a real rotor
      if (phase_a_i && phase_b_i)
        seq_err_o <= 1'b1;
      if (phase_a_i && !a_q)
      begin
        steps_o  <= steps_o + 16'h1;
        last_b_q <= 1'b0;
        if (!last_b_q)
          seq_err_o <= 1'b1;
      end
      if (phase_b_i && !b_q)
      begin
        steps_o  <= steps_o + 16'h1;
        last_b_q <= 1'b1;
        if (last_b_q)
          seq_err_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
